// ===== pkg/udc_defines.vh
`ifndef UDEC_DEFINES_VH
`define UDEC_DEFINES_VH

// Count range: eight BCD digits, zero to all nines.
`define UDEC_COUNT_MAX     32'h9999_9999
`define UDEC_COUNT_ZERO    32'h0000_0000
// Reset value of each word image of the count.
`define UDEC_WORD_ZERO     16'h0000
// Offset between a counter slot number and its current-value word address.
// Word addresses are octal, so the offset of 1000 is octal 1000.
`define UDEC_VALUE_OFFSET  16'h0200
// Each bidirectional counter spans two adjacent counter slots.
`define UDEC_SLOT_SPAN     16'h0002
// Preset source selections.
`define UDEC_SRC_CONST     2'h0
`define UDEC_SRC_WORDS     2'h1
`define UDEC_SRC_POINTER   2'h2

`endif

// ===== rtl/udc_bidirectional_counter.v
// Functional notes
// - Count-up rising edge adds one.
// - Count-down rising edge subtracts one.
// - Reset input on forces count to zero.
// - Count stays within zero to 99999999.
// - Count is double word over two slots.
// - Value word address is slot plus 1000.
// - Status on while count at least preset.
// - Preset from constant, word pair, or pointer.
// - Reset also clears the status bit.
`include "udc_defines.vh"

module udec_bidirectional_counter #(
    parameter SLOT_W = 16
) (
    // Clock and reset; one clock edge stands for one scan.
    input  wire              clk,
    input  wire              rst_n,
    // Discrete count inputs from the ladder logic.
    input  wire              count_up,
    input  wire              count_down,
    input  wire              count_reset,
    // Counter identity.
    input  wire [SLOT_W-1:0] counter_slot,
    // Preset selection and sources, all BCD.
    input  wire [1:0]        preset_src,
    input  wire [31:0]       preset_const,
    input  wire [15:0]       preset_word_lo,
    input  wire [15:0]       preset_word_hi,
    input  wire [31:0]       preset_pointed,
    // Results.
    output reg  [31:0]       count_value,
    output reg  [15:0]       value_word_lo,
    output reg  [15:0]       value_word_hi,
    output reg  [SLOT_W-1:0] counter_value_reference,
    output reg  [SLOT_W-1:0] next_free_slot,
    output reg               status
);

    // Input levels seen at the previous scan, for edge detection.
    reg         up_prev;
    reg         down_prev;
    // Next state of the count and of the status, and the chosen preset.
    reg  [31:0] next_count;
    reg         next_status;
    reg  [31:0] preset;
    // Qualified one-scan count requests.
    wire        up_edge;
    wire        down_edge;
    // Count bounds, seen from the current value.
    wire        at_ceiling;
    wire        at_floor;

    // Add a small step to a slot number. The sum is formed wide and
    // then cut to the slot width on purpose: with a narrow slot port
    // the mapping wraps rather than depending on how a tool trims it.
    function [SLOT_W-1:0] slot_add;
        input [SLOT_W-1:0]  slot;
        input [15:0]        step;
        reg   [SLOT_W+15:0] sum;
        begin
            sum      = {16'h0000, slot} + {{SLOT_W{1'b0}}, step};
            slot_add = sum[SLOT_W-1:0];
        end
    endfunction

    // Increment one BCD digit string by one, carrying decimal.
    function [31:0] bcd_inc;
        input [31:0] v;
        integer i;
        reg carry;
        begin
            carry = 1'b1;
            bcd_inc = v;
            for (i = 0; i < 8; i = i + 1) begin
                if (carry) begin
                    if (v[i*4 +: 4] == 4'h9) begin
                        bcd_inc[i*4 +: 4] = 4'h0;
                    end else begin
                        bcd_inc[i*4 +: 4] = v[i*4 +: 4] + 4'h1;
                        carry = 1'b0;
                    end
                end
            end
        end
    endfunction

    // Decrement one BCD digit string by one, borrowing decimal.
    function [31:0] bcd_dec;
        input [31:0] v;
        integer i;
        reg borrow;
        begin
            borrow = 1'b1;
            bcd_dec = v;
            for (i = 0; i < 8; i = i + 1) begin
                if (borrow) begin
                    if (v[i*4 +: 4] == 4'h0) begin
                        bcd_dec[i*4 +: 4] = 4'h9;
                    end else begin
                        bcd_dec[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
                        borrow = 1'b0;
                    end
                end
            end
        end
    endfunction

    // Bound flags for the saturation rule. The count never wraps: an edge
    // that would carry past all nines or borrow below zero is dropped, so
    // a chattering input parks the counter at a bound instead of flipping
    // it to the far end of the range.
    assign at_ceiling = (count_value == `UDEC_COUNT_MAX);
    assign at_floor   = (count_value == `UDEC_COUNT_ZERO);

    // Edges are taken against the previous scan's input levels; an edge
    // only counts while the opposite input is off. Holding one input on
    // therefore blocks the other, which the ladder logic has to respect.
    assign up_edge   = count_up & ~up_prev & ~count_down;
    assign down_edge = count_down & ~down_prev & ~count_up;

    // Preset selection. Packed BCD compares correctly as binary, so no
    // decimal conversion is needed. The pointer path carries only the
    // value that outside logic fetched; the fetch itself is not done here.
    always @* begin
        case (preset_src)
            `UDEC_SRC_CONST: preset = preset_const;
            `UDEC_SRC_WORDS: preset = {preset_word_hi, preset_word_lo};
            `UDEC_SRC_POINTER: preset = preset_pointed;
            // The spare code falls back to the constant.
            default: preset = preset_const;
        endcase
    end

    // Next count: reset dominates, then saturating up or down. Reset acts
    // as a level, so the count stays at zero for as long as it is held.
    always @* begin
        next_count = count_value;
        if (count_reset) begin
            next_count = `UDEC_COUNT_ZERO;
        end else if (up_edge) begin
            if (!at_ceiling) begin
                next_count = bcd_inc(count_value);
            end
        end else if (down_edge) begin
            if (!at_floor) begin
                next_count = bcd_dec(count_value);
            end
        end
    end

    // Next status: compared against the new count, so the flag never lags
    // the value read in the same scan. While reset is held the flag stays
    // off, even when the preset is zero and the compare alone would pass.
    always @* begin
        next_status = 1'b0;
        if (!count_reset) begin
            next_status = (next_count >= preset);
        end
    end

    // Edge history. It resets to the idle level of the inputs, so an input
    // that is already on when reset lifts is seen as a fresh edge.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            up_prev   <= 1'b0;
            down_prev <= 1'b0;
        end else begin
            up_prev   <= count_up;
            down_prev <= count_down;
        end
    end

    // Count register: one update per scan, nothing else writes it.
    // A single register keeps all eight digits coherent.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_value <= `UDEC_COUNT_ZERO;
        end else begin
            count_value <= next_count;
        end
    end

    // Word images of the count. They load from the next count rather than
    // from the count register, so both words change in the same scan as
    // the count and a reader never sees a torn pair.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            value_word_lo <= `UDEC_WORD_ZERO;
            value_word_hi <= `UDEC_WORD_ZERO;
        end else begin
            value_word_lo <= next_count[15:0];
            value_word_hi <= next_count[31:16];
        end
    end

    // Slot map. The value word address and the next usable slot follow
    // the slot number one scan late; the slot is expected to stay put
    // while the counter is in use, so the lag does no harm.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            counter_value_reference <= {SLOT_W{1'b0}};
            next_free_slot          <= {SLOT_W{1'b0}};
        end else begin
            counter_value_reference <= slot_add(counter_slot,
                                                `UDEC_VALUE_OFFSET);
            next_free_slot <= slot_add(counter_slot, `UDEC_SLOT_SPAN);
        end
    end

    // Status flag. It is registered here so that the output comes
    // straight from a flop, as the other results do.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status <= 1'b0;
        end else begin
            status <= next_status;
        end
    end

endmodule // udec_bidirectional_counter

// ===== dv/udc_chk_sva.sv
`include "udc_defines.vh"
module udec_chk #(
    parameter SLOT_W = 16
) (
    // Clock, reset and count inputs.
    input logic              clk,
    input logic              rst_n,
    input logic              count_up,
    input logic              count_down,
    input logic              count_reset,
    // Slot and preset.
    input logic [1:0]        preset_src,
    input logic [31:0]       preset_const,
    input logic [SLOT_W-1:0] counter_slot,
    // Results.
    input logic [31:0]       count_value,
    input logic [15:0]       value_word_lo,
    input logic [15:0]       value_word_hi,
    input logic [SLOT_W-1:0] counter_value_reference,
    input logic [SLOT_W-1:0] next_free_slot,
    input logic              status
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Steps skip digit carries so that a plain sum is the BCD sum.
    up_step_a: assert property (
        count_up && !$past(count_up) && !count_down && !count_reset
        && count_value[3:0] < 4'h9 |=> count_value == $past(count_value) + 1)
        else $error("count up step wrong");
    down_step_a: assert property (
        count_down && !$past(count_down) && !count_up && !count_reset
        && count_value[3:0] != 4'h0 |=> count_value == $past(count_value) - 1)
        else $error("count down step wrong");
    reset_clear_a: assert property (count_reset |=> !count_value && !status)
        else $error("reset did not clear");
    bcd_digits_a: assert property (
        count_value[3:0] <= 4'h9 && count_value[7:4] <= 4'h9
        && count_value[11:8] <= 4'h9 && count_value[15:12] <= 4'h9
        && count_value[19:16] <= 4'h9 && count_value[23:20] <= 4'h9
        && count_value[27:24] <= 4'h9 && count_value[31:28] <= 4'h9)
        else $error("count holds a digit above nine");
    floor_hold_a: assert property (
        !count_value && count_down && !count_up |=> !count_value)
        else $error("count went below zero");
    both_on_a: assert property (
        count_up && count_down && !count_reset |=> $stable(count_value))
        else $error("count moved with both inputs on");
    word_split_a: assert property (
        {value_word_hi, value_word_lo} == count_value)
        else $error("word pair differs from count");
    slot_map_a: assert property ($past(rst_n) |->
        counter_value_reference == $past(counter_slot) + `UDEC_VALUE_OFFSET
        && next_free_slot == $past(counter_slot) + `UDEC_SLOT_SPAN)
        else $error("slot mapping wrong");
    status_cmp_a: assert property (
        !count_reset && preset_src == `UDEC_SRC_CONST
        |=> status == (count_value >= $past(preset_const)))
        else $error("status does not match compare");
endmodule // udec_chk
bind udec_bidirectional_counter udec_chk #(.SLOT_W(SLOT_W)) chk (
    .clk                     (clk),
    .rst_n                   (rst_n),
    .count_up                (count_up),
    .count_down              (count_down),
    .count_reset             (count_reset),
    .preset_src              (preset_src),
    .preset_const            (preset_const),
    .counter_slot            (counter_slot),
    .count_value             (count_value),
    .value_word_lo           (value_word_lo),
    .value_word_hi           (value_word_hi),
    .counter_value_reference (counter_value_reference),
    .next_free_slot          (next_free_slot),
    .status                  (status)
);

// ===== dv/udc_ladder.sv
module udec_ladder (
    // Scan clock.
    input  wire logic clk,
    // Discrete count inputs, driven as ladder rungs would drive them.
    output logic      count_up,
    output logic      count_down,
    output logic      count_reset
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {count_reset, count_down, count_up} = 3'h0;
    // One scan on, one off, so every call makes a fresh edge.
    task scan(input logic [2:0] v);
        @(posedge clk) {count_reset, count_down, count_up} <= v;
        @(posedge clk) {count_reset, count_down, count_up} <= 3'h0;
    endtask
endmodule // udec_ladder

// ===== dv/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_n = 1'b0, status;
    logic [1:0] preset_src = 2'h0;
    logic [31:0] preset_const = 32'h3, preset_pointed = 32'h10, count_value;
    logic [15:0] preset_word_lo = 16'h2, preset_word_hi = 16'h0;
    logic [15:0] counter_slot = 16'h5, value_word_lo, value_word_hi;
    logic [15:0] counter_value_reference, next_free_slot;
    wire count_up, count_down, count_reset;
    int fail_count = 0, check_count = 0;
    always #5 clk = ~clk;
    udec_ladder lad (
        .clk         (clk),
        .count_up    (count_up),
        .count_down  (count_down),
        .count_reset (count_reset)
    );
    udec_bidirectional_counter dut (
        .clk                     (clk),
        .rst_n                   (rst_n),
        .count_up                (count_up),
        .count_down              (count_down),
        .count_reset             (count_reset),
        .counter_slot            (counter_slot),
        .preset_src              (preset_src),
        .preset_const            (preset_const),
        .preset_word_lo          (preset_word_lo),
        .preset_word_hi          (preset_word_hi),
        .preset_pointed          (preset_pointed),
        .count_value             (count_value),
        .value_word_lo           (value_word_lo),
        .value_word_hi           (value_word_hi),
        .counter_value_reference (counter_value_reference),
        .next_free_slot          (next_free_slot),
        .status                  (status)
    );
    task cmp(input logic [32:0] g, e);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask
    // Codes are {reset, down, up}; the result is read mid-cycle.
    task t(input logic [2:0] v, int n, logic [31:0] e, logic s);
        repeat (n) lad.scan(v);
        @(negedge clk);
        cmp({count_value, status}, {e, s});
        cmp({1'b0, value_word_hi, value_word_lo}, {1'b0, e});
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t(3'h0, 1, 32'h0, 1'b0);
        cmp({1'b0, counter_value_reference, next_free_slot}, 33'h02050007);
        t(3'h1, 3, 32'h3, 1'b1);
        t(3'h2, 1, 32'h2, 1'b0);
        t(3'h3, 1, 32'h2, 1'b0);
        @(posedge clk) preset_src <= 2'h1;
        t(3'h0, 1, 32'h2, 1'b1);
        @(posedge clk) preset_src <= 2'h2;
        t(3'h0, 1, 32'h2, 1'b0);
        t(3'h4, 1, 32'h0, 1'b0);
        t(3'h2, 1, 32'h0, 1'b0);
        t(3'h1, 10, 32'h10, 1'b1);
        // The spare source code must fall back to the constant, not the
        // pointer value, which is moved out of reach here.
        @(posedge clk) begin
            preset_src     <= 2'h3;
            preset_pointed <= 32'h20;
        end
        t(3'h0, 1, 32'h10, 1'b1);
        end_of_test;
    end
    // A hang costs a mismatch; the sequence needs well under 200 cycles.
    initial begin
        #50000;
        fail_count++;
        end_of_test;
    end
endmodule // tb_top
